// file: include/imam_pkg.sv
package imam_pkg;

   // ==========================================================================
   // widths and counts
   localparam int ADDR_W   = 32;
   localparam int IDX_W    = 18;
   localparam int NBLK     = 4;
   localparam int NVIEW    = 4;
   localparam int NENT     = 6;
   localparam int NPORT    = 3;
   localparam int PORT_DM  = 0;
   localparam int PORT_PM  = 1;
   localparam int PORT_IO  = 2;

   // ==========================================================================
   // sram capacity per word size, all the same bit total
   localparam int SRAM_BITS    = 3 * 1024 * 1024;
   localparam int SRAM_WORDS32 = SRAM_BITS / 32;
   localparam int SRAM_WORDS16 = SRAM_BITS / 16;
   localparam int SRAM_WORDS48 = SRAM_BITS / 48;

   // ==========================================================================
   // types
   typedef enum logic [1:0]
   {
      IMAM_REGION_PERIPH = 2'h0,
      IMAM_REGION_ROM    = 2'h1,
      IMAM_REGION_SRAM   = 2'h3,
      IMAM_REGION_NONE   = 2'h2
   } imam_region_type;

   typedef enum logic [1:0]
   {
      IMAM_W64 = 2'h0,
      IMAM_W48 = 2'h1,
      IMAM_W32 = 2'h2,
      IMAM_W16 = 2'h3
   } imam_width_type;

   // ==========================================================================
   // view windows
   localparam logic [31:0] PERIPH_HI = 32'h0003_FFFF;
   localparam logic [31:0] LONG_LO   = 32'h0004_0000;
   localparam logic [31:0] LONG_HI   = 32'h0007_FFFF;
   localparam logic [31:0] NORM_HI   = 32'h000F_FFFF;
   localparam logic [31:0] SHORT_HI  = 32'h001F_FFFF;

   // ==========================================================================
   // per-view entries: rom0, sram0, rom1, sram1, sram2, sram3
   localparam logic [1:0] ENT_BLOCK [NENT] =
      '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
   localparam logic [NENT-1:0] ENT_IS_ROM = 6'h05;

   localparam logic [31:0] MAP_LO [NVIEW][NENT] = '{
      '{32'h0004_0000, 32'h0004_C000, 32'h0005_0000,
        32'h0005_C000, 32'h0006_0000, 32'h0007_0000},
      '{32'h0008_0000, 32'h0009_0000, 32'h000A_0000,
        32'h000B_0000, 32'h000C_0000, 32'h000E_0000},
      '{32'h0008_0000, 32'h0009_8000, 32'h000A_0000,
        32'h000B_8000, 32'h000C_0000, 32'h000E_0000},
      '{32'h0010_0000, 32'h0013_0000, 32'h0014_0000,
        32'h0017_0000, 32'h0018_0000, 32'h001C_0000}};

   localparam logic [31:0] MAP_HI [NVIEW][NENT] = '{
      '{32'h0004_7FFF, 32'h0004_FFFF, 32'h0005_7FFF,
        32'h0005_FFFF, 32'h0006_1FFF, 32'h0007_1FFF},
      '{32'h0008_AAA9, 32'h0009_5554, 32'h000A_AAA9,
        32'h000B_5554, 32'h000C_2AA9, 32'h000E_2AA9},
      '{32'h0008_FFFF, 32'h0009_FFFF, 32'h000A_FFFF,
        32'h000B_FFFF, 32'h000C_3FFF, 32'h000E_3FFF},
      '{32'h0011_FFFF, 32'h0013_FFFF, 32'h0015_FFFF,
        32'h0017_FFFF, 32'h0018_7FFF, 32'h001C_7FFF}};

endpackage

// file: design/imam_decode.sv
`timescale 1ns/1ps

module imam_decode
(
   input  wire logic [31:0]              addr,
   input  wire logic                     ext_sel,
   output imam_pkg::imam_region_type     region,
   output logic [1:0]                    block,
   output imam_pkg::imam_width_type      width,
   output logic [imam_pkg::IDX_W-1:0]    index
);

   // ==========================================================================
   // range test
   function automatic logic imam_in_range
   (
      input logic [31:0] a,
      input logic [31:0] lo,
      input logic [31:0] hi
   );
      imam_in_range = (a >= lo) && (a <= hi);
   endfunction

   // ==========================================================================
   // decode
   logic        in_view;
   logic [31:0] offset;

   always_comb
   begin
      region  = imam_pkg::IMAM_REGION_NONE;
      block   = '0;
      width   = imam_pkg::IMAM_W32;
      index   = '0;
      in_view = 1'b0;
      offset  = '0;
      if (addr <= imam_pkg::PERIPH_HI)
      begin
         region = imam_pkg::IMAM_REGION_PERIPH;                 // [RULE1]
         index  = addr[imam_pkg::IDX_W-1:0];
      end
      else if (imam_in_range(addr, imam_pkg::LONG_LO, imam_pkg::LONG_HI))
      begin
         width   = imam_pkg::IMAM_W64;                          // [RULE9]
         in_view = 1'b1;
      end
      else if (addr <= imam_pkg::NORM_HI)
      begin
         width   = ext_sel ? imam_pkg::IMAM_W48 : imam_pkg::IMAM_W32;
         in_view = 1'b1;                                        // [RULE9]
      end
      else if (addr <= imam_pkg::SHORT_HI)
      begin
         width   = imam_pkg::IMAM_W16;                          // [RULE9]
         in_view = 1'b1;
      end
      // above the short view nothing is selected [RULE6]
      if (in_view)
      begin
         // gaps between entries stay reserved [RULE2] [RULE3] [RULE4] [RULE5]
         for (int e = 0; e < imam_pkg::NENT; e++)
         begin
            if (imam_in_range(addr, imam_pkg::MAP_LO[int'(width)][e],
                              imam_pkg::MAP_HI[int'(width)][e]))
            begin
               region = imam_pkg::ENT_IS_ROM[e] ?
                        imam_pkg::IMAM_REGION_ROM :
                        imam_pkg::IMAM_REGION_SRAM;             // [RULE12]
               block  = imam_pkg::ENT_BLOCK[e];
               offset = addr - imam_pkg::MAP_LO[int'(width)][e];
               index  = offset[imam_pkg::IDX_W-1:0];            // [RULE10]
            end
         end
      end
   end

endmodule // imam_decode

// file: design/imam_map.sv
`timescale 1ns/1ps

// Summary of operation
// RULE1 - addresses up to 0x0003FFFF select peripheral registers only.
// RULE2 - 32-bit view 0x00090000-0x00097FFF is reserved, no memory selected.
// RULE3 - 32-bit view 0x000B0000-0x000B7FFF is reserved, no memory selected.
// RULE4 - 16-bit view 0x00120000-0x0012FFFF is reserved.
// RULE5 - 16-bit view 0x00188000-0x001BFFFF is reserved, no block selected.
// RULE6 - addresses from 0x00200000 upward are reserved, nothing selected.
// RULE7 - each block serves core and io processor independently, one cycle.
// RULE8 - two core data transfers plus one io transfer accepted per cycle; the code makes the pm transfer wait when both core buses hit one block.
// RULE9 - access width 64, 48, 32 or 16 bits follows the address view.
// RULE10 - sram holds 96K 32-bit, 192K 16-bit or 64K 48-bit words.
// RULE11 - core buses on different blocks both complete in one cycle.
// RULE12 - rom blocks 0-1 and sram blocks 0-3 decoded per view.

module imam_map
#(
   parameter int NBLK = imam_pkg::NBLK
)
(
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   input  wire logic                      dm_valid,
   input  wire logic [31:0]               dm_addr,
   input  wire logic                      dm_ext,
   output logic                           dm_ready,
   output logic                           dm_resp_valid,
   output imam_pkg::imam_region_type      dm_resp_region,
   output logic [1:0]                     dm_resp_block,
   output imam_pkg::imam_width_type       dm_resp_width,
   output logic [imam_pkg::IDX_W-1:0]     dm_resp_index,
   input  wire logic                      pm_valid,
   input  wire logic [31:0]               pm_addr,
   input  wire logic                      pm_ext,
   output logic                           pm_ready,
   output logic                           pm_resp_valid,
   output imam_pkg::imam_region_type      pm_resp_region,
   output logic [1:0]                     pm_resp_block,
   output imam_pkg::imam_width_type       pm_resp_width,
   output logic [imam_pkg::IDX_W-1:0]     pm_resp_index,
   input  wire logic                      io_valid,
   input  wire logic [31:0]               io_addr,
   input  wire logic                      io_ext,
   output logic                           io_ready,
   output logic                           io_resp_valid,
   output imam_pkg::imam_region_type      io_resp_region,
   output logic [1:0]                     io_resp_block,
   output imam_pkg::imam_width_type       io_resp_width,
   output logic [imam_pkg::IDX_W-1:0]     io_resp_index,
   output logic [NBLK-1:0]                blk_dm_sel,
   output logic [NBLK-1:0]                blk_pm_sel,
   output logic [NBLK-1:0]                blk_io_sel
);

   // ==========================================================================
   // helpers
   function automatic logic imam_is_mem(input imam_pkg::imam_region_type r);
      imam_is_mem = (r == imam_pkg::IMAM_REGION_ROM) ||
                    (r == imam_pkg::IMAM_REGION_SRAM);
   endfunction

   function automatic logic [NBLK-1:0] imam_onehot(input logic [1:0] b);
      imam_onehot = '0;
      imam_onehot[b] = 1'b1;
   endfunction

   // ==========================================================================
   // request gathering
   localparam int NP = imam_pkg::NPORT;

   logic                           req_valid [NP];
   logic [31:0]                    req_addr  [NP];
   logic                           req_ext   [NP];
   logic                           req_ready [NP];
   logic                           take      [NP];
   imam_pkg::imam_region_type      dec_region [NP];
   logic [1:0]                     dec_block  [NP];
   imam_pkg::imam_width_type       dec_width  [NP];
   logic [imam_pkg::IDX_W-1:0]     dec_index  [NP];

   assign req_valid[imam_pkg::PORT_DM] = dm_valid;
   assign req_addr[imam_pkg::PORT_DM]  = dm_addr;
   assign req_ext[imam_pkg::PORT_DM]   = dm_ext;

   assign req_valid[imam_pkg::PORT_PM] = pm_valid;
   assign req_addr[imam_pkg::PORT_PM]  = pm_addr;
   assign req_ext[imam_pkg::PORT_PM]   = pm_ext;

   assign req_valid[imam_pkg::PORT_IO] = io_valid;
   assign req_addr[imam_pkg::PORT_IO]  = io_addr;
   assign req_ext[imam_pkg::PORT_IO]   = io_ext;

   // ==========================================================================
   // one decoder per bus, all working in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++)
      begin : g_dec
         imam_decode u_dec
         (
            .addr    (req_addr[gi]),
            .ext_sel (req_ext[gi]),
            .region  (dec_region[gi]),
            .block   (dec_block[gi]),
            .width   (dec_width[gi]),
            .index   (dec_index[gi])
         );
      end
   endgenerate

   // ==========================================================================
   // acceptance
   logic core_clash;

   always_comb
   begin
      // both core buses on one block: program bus waits a cycle
      core_clash = req_valid[imam_pkg::PORT_DM] &&
                   req_valid[imam_pkg::PORT_PM] &&
                   imam_is_mem(dec_region[imam_pkg::PORT_DM]) &&
                   imam_is_mem(dec_region[imam_pkg::PORT_PM]) &&
                   (dec_block[imam_pkg::PORT_DM] ==
                    dec_block[imam_pkg::PORT_PM]);
      req_ready[imam_pkg::PORT_DM] = 1'b1;                      // [RULE8]
      req_ready[imam_pkg::PORT_PM] = !core_clash;               // [RULE11]
      req_ready[imam_pkg::PORT_IO] = 1'b1;                      // [RULE7]
      for (int p = 0; p < NP; p++)
      begin
         take[p] = req_valid[p] && req_ready[p];
      end
   end

   assign dm_ready = req_ready[imam_pkg::PORT_DM];
   assign pm_ready = req_ready[imam_pkg::PORT_PM];
   assign io_ready = req_ready[imam_pkg::PORT_IO];

   // ==========================================================================
   // response and block select state
   logic                           rsp_valid  [NP];
   imam_pkg::imam_region_type      rsp_region [NP];
   logic [1:0]                     rsp_block  [NP];
   imam_pkg::imam_width_type       rsp_width  [NP];
   logic [imam_pkg::IDX_W-1:0]     rsp_index  [NP];
   logic [NBLK-1:0]                rsp_sel    [NP];

   logic                           next_rsp_valid  [NP];
   imam_pkg::imam_region_type      next_rsp_region [NP];
   logic [1:0]                     next_rsp_block  [NP];
   imam_pkg::imam_width_type       next_rsp_width  [NP];
   logic [imam_pkg::IDX_W-1:0]     next_rsp_index  [NP];
   logic [NBLK-1:0]                next_rsp_sel    [NP];

   always_comb
   begin
      for (int p = 0; p < NP; p++)
      begin
         // every taken access answers on the next edge [RULE7] [RULE8]
         next_rsp_valid[p]  = take[p];
         next_rsp_region[p] = take[p] ? dec_region[p] :
                              imam_pkg::IMAM_REGION_NONE;
         next_rsp_block[p]  = take[p] ? dec_block[p] : '0;
         next_rsp_width[p]  = take[p] ? dec_width[p] :
                              imam_pkg::IMAM_W32;               // [RULE9]
         next_rsp_index[p]  = take[p] ? dec_index[p] : '0;
         next_rsp_sel[p]    = (take[p] && imam_is_mem(dec_region[p])) ?
                              imam_onehot(dec_block[p]) : '0;   // [RULE12]
      end
   end

   always_ff @(posedge ref_clk)
   begin
      for (int p = 0; p < NP; p++)
      begin
         if (!rst_n)
         begin
            rsp_valid[p]  <= 1'b0;
            rsp_region[p] <= imam_pkg::IMAM_REGION_NONE;
            rsp_block[p]  <= '0;
            rsp_width[p]  <= imam_pkg::IMAM_W32;
            rsp_index[p]  <= '0;
            rsp_sel[p]    <= '0;
         end
         else
         begin
            rsp_valid[p]  <= next_rsp_valid[p];
            rsp_region[p] <= next_rsp_region[p];
            rsp_block[p]  <= next_rsp_block[p];
            rsp_width[p]  <= next_rsp_width[p];
            rsp_index[p]  <= next_rsp_index[p];
            rsp_sel[p]    <= next_rsp_sel[p];
         end
      end
   end

   // ==========================================================================
   // data memory bus outputs
   assign dm_resp_valid  = rsp_valid[imam_pkg::PORT_DM];
   assign dm_resp_region = rsp_region[imam_pkg::PORT_DM];
   assign dm_resp_block  = rsp_block[imam_pkg::PORT_DM];
   assign dm_resp_width  = rsp_width[imam_pkg::PORT_DM];
   assign dm_resp_index  = rsp_index[imam_pkg::PORT_DM];

   // ==========================================================================
   // program memory bus outputs
   assign pm_resp_valid  = rsp_valid[imam_pkg::PORT_PM];
   assign pm_resp_region = rsp_region[imam_pkg::PORT_PM];
   assign pm_resp_block  = rsp_block[imam_pkg::PORT_PM];
   assign pm_resp_width  = rsp_width[imam_pkg::PORT_PM];
   assign pm_resp_index  = rsp_index[imam_pkg::PORT_PM];

   // ==========================================================================
   // io processor bus outputs
   assign io_resp_valid  = rsp_valid[imam_pkg::PORT_IO];
   assign io_resp_region = rsp_region[imam_pkg::PORT_IO];
   assign io_resp_block  = rsp_block[imam_pkg::PORT_IO];
   assign io_resp_width  = rsp_width[imam_pkg::PORT_IO];
   assign io_resp_index  = rsp_index[imam_pkg::PORT_IO];

   // ==========================================================================
   // block selects
   assign blk_dm_sel     = rsp_sel[imam_pkg::PORT_DM];
   assign blk_pm_sel     = rsp_sel[imam_pkg::PORT_PM];
   assign blk_io_sel     = rsp_sel[imam_pkg::PORT_IO];

endmodule // imam_map

// file: verification/imam_map_monitor.sv
`timescale 1ns/1ps

// ==========================================================================
// decoder port checks
module imam_map_monitor
#(
   parameter int NBLK = 4
)
(
   input wire logic                      ref_clk,
   input wire logic                      rst_n,
   input wire logic                      dm_valid,
   input wire logic [31:0]               dm_addr,
   input wire logic                      dm_ext,
   input wire logic                      dm_ready,
   input wire logic                      dm_resp_valid,
   input wire imam_pkg::imam_region_type dm_resp_region,
   input wire logic [1:0]                dm_resp_block,
   input wire logic [NBLK-1:0]           blk_dm_sel,
   input wire logic                      pm_valid,
   input wire logic                      pm_ready,
   input wire logic                      pm_resp_valid,
   input wire logic                      io_valid,
   input wire logic [31:0]               io_addr,
   input wire logic                      io_ready,
   input wire logic                      io_resp_valid,
   input wire imam_pkg::imam_region_type io_resp_region,
   input wire logic [NBLK-1:0]           blk_io_sel
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence dm_take;
      dm_valid && dm_ready;
   endsequence
   sequence dm_none_next;
      ##1 dm_resp_region == imam_pkg::IMAM_REGION_NONE && blk_dm_sel == '0;
   endsequence

   never_refused_a:
      assert property (io_ready && dm_ready)
      else $error("dm or io request refused");
   pm_stall_cause_a:
      assert property (!pm_ready |-> dm_valid && pm_valid)
      else $error("pm stalled without a core clash");
   dm_answer_a:
      assert property (dm_take |=> dm_resp_valid)
      else $error("dm response missing one cycle after take");
   pm_answer_a:
      assert property (pm_valid && pm_ready |=> pm_resp_valid)
      else $error("pm response missing one cycle after take");
   io_answer_a:
      assert property (io_valid |=> io_resp_valid)
      else $error("io response missing one cycle after take");
   dm_idle_a:
      assert property (!dm_valid |=> !dm_resp_valid && blk_dm_sel == '0)
      else $error("dm response without request");
   periph_map_a:
      assert property (dm_take ##0 dm_addr <= 32'h0003_FFFF |=>
         dm_resp_region == imam_pkg::IMAM_REGION_PERIPH && blk_dm_sel == '0)
      else $error("low address not decoded as register space");
   norm_gap_a:
      assert property (dm_take ##0 !dm_ext && dm_addr inside
         {[32'h0009_0000:32'h0009_7FFF], [32'h000B_0000:32'h000B_7FFF]}
         |-> dm_none_next)
      else $error("normal word gap selected memory");
   short_gap_a:
      assert property (dm_take ##0 dm_addr inside
         {[32'h0012_0000:32'h0012_FFFF], [32'h0018_8000:32'h001B_FFFF]}
         |-> dm_none_next)
      else $error("short word gap selected memory");
   top_reserved_a:
      assert property (io_valid && io_addr >= 32'h0020_0000 |=>
         io_resp_region == imam_pkg::IMAM_REGION_NONE && blk_io_sel == '0)
      else $error("high address selected memory");
   sel_match_a:
      assert property (dm_resp_region == imam_pkg::IMAM_REGION_SRAM |->
         blk_dm_sel == (NBLK'(1) << dm_resp_block))
      else $error("block select differs from block number");
endmodule // imam_map_monitor

bind imam_map imam_map_monitor #(.NBLK(NBLK)) u_mon (.ref_clk, .rst_n,
   .dm_valid, .dm_addr, .dm_ext, .dm_ready, .dm_resp_valid, .dm_resp_region,
   .dm_resp_block, .blk_dm_sel, .pm_valid, .pm_ready, .pm_resp_valid,
   .io_valid, .io_addr, .io_ready, .io_resp_valid, .io_resp_region,
   .blk_io_sel);

// file: verification/imam_core_model.sv
`timescale 1ns/1ps

// ==========================================================================
// requester on one core or io bus
module imam_core_model
(
   input  wire logic        ref_clk,
   input  wire logic        ready,
   output logic             valid,
   output logic [31:0]      addr,
   output logic             ext
);
   initial
   begin
      valid = 1'h0;
      addr = 32'h0;
      ext = 1'h0;
   end

   // holds the request until ready is seen high at a rising edge, for at most 8 rising edges
   task automatic request(input logic [31:0] a, input logic e, output bit ok);
      int n;
      ok = 1'h0;
      @(negedge ref_clk);
      valid = 1'h1;
      addr = a;
      ext = e;
      for (n = 0; n < 8 && !ok; n++)
      begin
         @(posedge ref_clk);
         ok = (ready === 1'h1);
      end
      @(negedge ref_clk);
      valid = 1'h0;
      addr = ~a;
      ext = ~e;
   endtask
endmodule // imam_core_model

// file: verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   logic ref_clk, rst_n;
   logic dm_valid, dm_ext, dm_ready, dm_resp_valid;
   logic pm_valid, pm_ext, pm_ready, pm_resp_valid;
   logic io_valid, io_ext, io_ready, io_resp_valid;
   logic [31:0] dm_addr, pm_addr, io_addr;
   imam_pkg::imam_region_type dm_resp_region, pm_resp_region, io_resp_region;
   imam_pkg::imam_width_type dm_resp_width, pm_resp_width, io_resp_width;
   logic [1:0] dm_resp_block, pm_resp_block, io_resp_block;
   logic [17:0] dm_resp_index, pm_resp_index, io_resp_index;
   logic [3:0] blk_dm_sel, blk_pm_sel, blk_io_sel;
   int fail_count = 0;
   int checked = 0;

   imam_map #(.NBLK(4)) u_dut (.ref_clk, .rst_n, .dm_valid, .dm_addr,
      .dm_ext, .dm_ready, .dm_resp_valid, .dm_resp_region, .dm_resp_block,
      .dm_resp_width, .dm_resp_index, .pm_valid, .pm_addr, .pm_ext, .pm_ready,
      .pm_resp_valid, .pm_resp_region, .pm_resp_block, .pm_resp_width,
      .pm_resp_index, .io_valid, .io_addr, .io_ext, .io_ready, .io_resp_valid,
      .io_resp_region, .io_resp_block, .io_resp_width, .io_resp_index,
      .blk_dm_sel, .blk_pm_sel, .blk_io_sel);
   imam_core_model u_dm (.ref_clk, .ready(dm_ready), .valid(dm_valid),
      .addr(dm_addr), .ext(dm_ext));
   imam_core_model u_pm (.ref_clk, .ready(pm_ready), .valid(pm_valid),
      .addr(pm_addr), .ext(pm_ext));
   imam_core_model u_io (.ref_clk, .ready(io_ready), .valid(io_valid),
      .addr(io_addr), .ext(io_ext));

   always #2 ref_clk = ~ref_clk;

   // ==========================================================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic dm_case(input logic [31:0] a, input logic e,
      input logic [1:0] rg, input logic [1:0] bk, input logic [1:0] wd,
      input logic [17:0] ix, input bit full);
      bit ok;
      u_dm.request(a, e, ok);
      chk("dm taken", ok, 1'h1);
      chk("dm valid", dm_resp_valid, 1'h1);
      chk("dm region", dm_resp_region, rg);
      chk("dm sel", blk_dm_sel, rg[0] ? 4'h1 << bk : 4'h0);
      if (full)
      begin
         chk("dm block", dm_resp_block, bk);
         chk("dm width", dm_resp_width, wd);
         chk("dm index", dm_resp_index, ix);
      end
   endtask

   // ==========================================================================
   // scenarios
   task automatic t_views;
      bit ok;
      dm_case(32'h0003_FFFF, 1'h0, 2'h0, 2'h0, 2'h2, 18'h3FFFF, 1);
      dm_case(32'h0004_0000, 1'h0, 2'h1, 2'h0, 2'h0, 18'h0, 1);
      dm_case(32'h0009_0000, 1'h0, 2'h2, 2'h0, 2'h2, 18'h0, 0);
      dm_case(32'h0009_0000, 1'h1, 2'h3, 2'h0, 2'h1, 18'h0, 1);
      dm_case(32'h0009_8000, 1'h0, 2'h3, 2'h0, 2'h2, 18'h0, 1);
      dm_case(32'h000B_7FFF, 1'h0, 2'h2, 2'h0, 2'h2, 18'h0, 0);
      dm_case(32'h000B_FFFF, 1'h0, 2'h3, 2'h1, 2'h2, 18'h7FFF, 1);
      dm_case(32'h0012_0000, 1'h0, 2'h2, 2'h0, 2'h3, 18'h0, 0);
      dm_case(32'h0018_7FFF, 1'h0, 2'h3, 2'h2, 2'h3, 18'h7FFF, 1);
      dm_case(32'h0018_8000, 1'h0, 2'h2, 2'h0, 2'h3, 18'h0, 0);
      dm_case(32'h001B_FFFF, 1'h0, 2'h2, 2'h0, 2'h3, 18'h0, 0);
      dm_case(32'h001C_0000, 1'h0, 2'h3, 2'h3, 2'h3, 18'h0, 1);
      dm_case(32'h000E_2AA9, 1'h1, 2'h3, 2'h3, 2'h1, 18'h2AA9, 1);
      dm_case(32'h0020_0000, 1'h0, 2'h2, 2'h0, 2'h2, 18'h0, 1);
      u_io.request(32'hFFFF_FFFF, 1'h0, ok);
      chk("io region", io_resp_region, 2'h2);
      chk("io width", io_resp_width, 2'h2);
      chk("io taken", ok, 1'h1);
      u_io.request(32'h000E_0010, 1'h0, ok);
      chk("io valid", io_resp_valid, 1'h1);
      chk("io block", io_resp_block, 2'h3);
      chk("io index", io_resp_index, 18'h10);
      chk("io sel", blk_io_sel, 4'h8);
      $display("test views done");
   endtask

   task automatic t_parallel;
      bit k0, k1, k2;
      fork
         u_dm.request(32'h0004_0000, 1'h0, k0);
         u_pm.request(32'h0014_0003, 1'h0, k1);
         u_io.request(32'h0013_0005, 1'h0, k2);
      join
      chk("all taken", {k0, k1, k2}, 3'h7);
      chk("dm sel", blk_dm_sel, 4'h1);
      chk("pm block", pm_resp_block, 2'h1);
      chk("pm width", pm_resp_width, 2'h3);
      chk("pm valid", pm_resp_valid, 1'h1);
      chk("pm index", pm_resp_index, 18'h3);
      chk("io index", io_resp_index, 18'h5);
      chk("io region", io_resp_region, 2'h3);
      chk("io sel", blk_io_sel, 4'h1);
      $display("test parallel done");
   endtask

   task automatic t_clash;
      bit k0, k1;
      fork
         begin
            u_dm.request(32'h000A_0000, 1'h0, k0);
            chk("dm block", dm_resp_block, 2'h1);
            chk("pm early", pm_resp_valid, 1'h0);
         end
         u_pm.request(32'h000B_8000, 1'h0, k1);
         begin
            @(negedge ref_clk);
            #1;
            chk("pm ready", pm_ready, 1'h0);
         end
      join
      chk("pm taken", k1, 1'h1);
      chk("pm region", pm_resp_region, 2'h3);
      chk("pm sel", blk_pm_sel, 4'h2);
      chk("dm after", dm_resp_valid, 1'h0);
      $display("test clash done");
   endtask

   initial
   begin
      ref_clk = 1'h0;
      rst_n = 1'h0;
      repeat (16) @(negedge ref_clk);
      rst_n = 1'h1;
      t_views;
      t_parallel;
      t_clash;
      stop_test;
   end

   initial
   begin
      #100000;
      fail_count++;
      stop_test;
   end
endmodule // tb_top
